// ---- lsfm_fault_monitor.sv ----
`timescale 1ns/1ps
`include "lsfm_map.svh"

// How it works
// - Digital bias monitor trips when bias current is at or above its threshold.
// - Digital photodiode monitor trips at the power fault threshold register value.
// - Converter settings bit 7 set powers the converter down.
// - Converter settings bit 6 set stops the converter oscillator.
// - Input select 00 temperature, 01 supply, 10 photodiode, 11 bias monitor.
// - Ten-bit result: upper eight bits at 0x0E, lower two at 0x0F.
// - Analog bias fault when the bias monitor comparator reports above reference.
// - With digital bias select, the threshold compare replaces the comparator.
// - Analog power fault needs the comparator high and the trip enable set.
// - With digital power select, the threshold compare raises the power fault.
// - Photodiode current above one and a half times its set value is a fault.
// - Bias control value falling by more than half in one step is a fault.
// - Faults act on outputs only while fault detection is enabled.
// - A fault zeroes bias and modulation and latches the fault output.
// - Fault output is low while shutoff is high or the chip is off.
// - Without a fault, operation resumes after the disable negate time.
// - A fault still present on re-enable reasserts the fault output at once.
// - Control register bit 7 enables the chip; taking it low clears a fault.
// - Control register bit 3 turns fault detection on.
// - Monitor register bits 2, 1, 0: power trip, power digital, bias digital.
module lsfm_fault_monitor
    import lsfm_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR     = `LSFM_DEV_ADDR,
    parameter int         LATCH_RST_NS = `LSFM_LATCH_RST_NS,
    parameter int         NEGATE_NS    = `LSFM_NEGATE_NS
) (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       scl_clk,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       output_shutoff_in,
    input  wire logic       bias_monitor_pin,
    input  wire logic       power_monitor_pin,
    input  wire logic [7:0] bias_meas,
    input  wire logic [7:0] pd_meas,
    input  wire logic [9:0] pd_current,
    input  wire logic [9:0] pd_setpoint,
    input  wire logic [9:0] bias_dac,
    input  wire logic       bias_dac_load,
    input  wire logic [9:0] conv_data,
    input  wire logic       conv_done,
    output logic            fault_out,
    output logic            bias_force_zero,
    output logic            mod_force_zero,
    output logic            conv_power_down,
    output logic            conv_osc_off,
    output logic [1:0]      conv_input_select,
    output logic            chip_running
);

    localparam int LATCH_RAW = (LATCH_RST_NS * `LSFM_CLK_MHZ + 999) / 1000;
    localparam int NEGATE_RAW = (NEGATE_NS * `LSFM_CLK_MHZ + 999) / 1000;
    localparam logic [15:0] LATCH_CYC = 16'((LATCH_RAW < 1) ? 1 : LATCH_RAW);
    localparam logic [15:0] NEGATE_CYC = 16'((NEGATE_RAW < 1) ? 1 : NEGATE_RAW);

    function automatic logic at_or_above(input logic [7:0] level,
                                         input logic [7:0] limit);
        return level >= limit;
    endfunction

    function automatic logic [7:0] ptr_step(input logic [7:0] ptr);
        return 8'(ptr + 8'h01);
    endfunction

    // Link side, clocked by the serial clock.
    lsfm_link_state_t lk_state;
    logic [3:0]       lk_bits;
    logic [6:0]       lk_shift;
    logic             lk_ack;
    logic [7:0]       lk_tx;
    logic [7:0]       lk_ptr;
    logic             lk_tgl;
    logic             lk_msg_wr;
    logic [7:0]       lk_msg_ptr;
    logic [7:0]       lk_msg_data;
    logic [7:0]       lk_byte;

    // System side.
    logic             frame_rst;
    logic             in_frame;
    logic [5:0]       sync_d;
    logic [5:0]       sync_q;
    logic             scl_s;
    logic             sda_s;
    logic             bias_pin_s;
    logic             power_pin_s;
    logic             shutoff_s;
    logic             tgl_s;
    logic             scl_d;
    logic             sda_d;
    logic             tgl_d;
    logic             msg_evt;
    logic [7:0]       sys_ptr;
    logic [7:0]       rd_byte;
    logic [7:0]       ctrl0;
    logic [2:0]       mon_cfg;
    logic [7:0]       bias_fault_threshold;
    logic [7:0]       power_fault_threshold;
    logic [3:0]       conv_cfg;
    logic [9:0]       conv_result;
    logic [9:0]       prev_dac;
    logic             bias_fault;
    logic             power_fault;
    logic             pd_over;
    logic             dac_drop;
    logic             fault_cond;
    logic             disabled;
    logic             fault_latch;
    logic             next_fault_latch;
    logic [15:0]      dis_cnt;
    logic [15:0]      run_cnt;
    logic             running;

    lsfm_mem_if mem ();

    assign lk_byte = {lk_shift, sda_in};
    assign sda_out = 1'b0;

    // Bit counter, byte decode and acknowledge scheduling.
    always_ff @(posedge scl_clk or posedge frame_rst) begin
        if (frame_rst) begin
            lk_bits  <= 4'h0;
            lk_shift <= 7'h00;
            lk_ack   <= 1'b0;
            lk_state <= LSFM_LK_ADDR;
        end else if (lk_bits != 4'h8) begin
            lk_shift <= lk_byte[6:0];
            lk_bits  <= lk_bits + 4'h1;
            if (lk_bits == 4'h7) begin
                case (lk_state)
                    LSFM_LK_ADDR: begin
                        if (lk_byte[7:1] == DEV_ADDR) begin
                            lk_ack   <= 1'b1;
                            lk_state <= lk_byte[0] ? LSFM_LK_READ : LSFM_LK_REG;
                        end else begin
                            lk_state <= LSFM_LK_IDLE;
                        end
                    end
                    LSFM_LK_REG: begin
                        lk_ack   <= 1'b1;
                        lk_state <= LSFM_LK_WRITE;
                    end
                    LSFM_LK_WRITE: begin
                        lk_ack <= 1'b1;
                    end
                    default: begin
                        lk_ack <= 1'b0;
                    end
                endcase
            end
        end else begin
            lk_bits <= 4'h0;
            lk_ack  <= 1'b0;
            if (lk_state == LSFM_LK_READ && sda_in) begin
                lk_state <= LSFM_LK_IDLE;
            end
        end
    end

    // Pointer, transmit byte and messages toward the system side.
    always_ff @(posedge scl_clk or posedge reset) begin
        if (reset) begin
            lk_ptr      <= 8'h00;
            lk_tx       <= 8'h00;
            lk_tgl      <= 1'b0;
            lk_msg_wr   <= 1'b0;
            lk_msg_ptr  <= 8'h00;
            lk_msg_data <= 8'h00;
        end else if (lk_bits == 4'h7 && lk_state == LSFM_LK_REG) begin
            lk_ptr     <= lk_byte;
            lk_msg_wr  <= 1'b0;
            lk_msg_ptr <= lk_byte;
            lk_tgl     <= ~lk_tgl;
        end else if (lk_bits == 4'h7 && lk_state == LSFM_LK_WRITE) begin
            lk_ptr      <= ptr_step(lk_ptr);
            lk_msg_wr   <= 1'b1;
            lk_msg_ptr  <= lk_ptr;
            lk_msg_data <= lk_byte;
            lk_tgl      <= ~lk_tgl;
        end else if (lk_bits == 4'h8 && lk_state == LSFM_LK_READ && !sda_in) begin
            lk_tx      <= rd_byte;
            lk_ptr     <= ptr_step(lk_ptr);
            lk_msg_wr  <= 1'b0;
            lk_msg_ptr <= ptr_step(lk_ptr);
            lk_tgl     <= ~lk_tgl;
        end
    end

    // Data line changes only while the serial clock is low.
    always_ff @(negedge scl_clk or posedge frame_rst) begin
        if (frame_rst) begin
            sda_oe <= 1'b0;
        end else begin
            sda_oe <= (lk_ack && lk_bits == 4'h8) ||
                      (lk_state == LSFM_LK_READ && lk_bits != 4'h8 && !lk_tx[~lk_bits[2:0]]);
        end
    end

    assign sync_d = {lk_tgl, output_shutoff_in, power_monitor_pin, bias_monitor_pin,
                     sda_in, scl_clk};

    lsfm_sync2 #(
        .WIDTH (6)
    ) u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .d       (sync_d),
        .q       (sync_q)
    );

    assign scl_s       = sync_q[0];
    assign sda_s       = sync_q[1];
    assign bias_pin_s  = sync_q[2];
    assign power_pin_s = sync_q[3];
    assign shutoff_s   = sync_q[4];
    assign tgl_s       = sync_q[5];
    assign msg_evt     = tgl_s ^ tgl_d;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            tgl_d <= 1'b0;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            tgl_d <= tgl_s;
        end
    end

    // A start holds the link logic in reset until the first low clock phase; a stop holds it there until the next start.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            frame_rst <= 1'b1;
            in_frame  <= 1'b0;
        end else if (scl_s && scl_d && sda_d && !sda_s) begin
            frame_rst <= 1'b1;
            in_frame  <= 1'b1;
        end else if (scl_s && scl_d && !sda_d && sda_s) begin
            frame_rst <= 1'b1;
            in_frame  <= 1'b0;
        end else if (in_frame && !scl_s) begin
            frame_rst <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sys_ptr <= 8'h00;
        end else if (msg_evt) begin
            sys_ptr <= lk_msg_wr ? ptr_step(lk_msg_ptr) : lk_msg_ptr;
        end
    end

    // Host register writes.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl0                 <= `LSFM_RST_CTRL0;
            mon_cfg               <= `LSFM_RST_MON;
            bias_fault_threshold  <= `LSFM_RST_THR;
            power_fault_threshold <= `LSFM_RST_THR;
            conv_cfg              <= `LSFM_RST_CONV;
        end else if (msg_evt && lk_msg_wr) begin
            if (lk_msg_ptr == `LSFM_REG_CTRL0) begin
                ctrl0 <= lk_msg_data;
            end else if (lk_msg_ptr == `LSFM_REG_MON) begin
                mon_cfg <= lk_msg_data[2:0];
            end else if (lk_msg_ptr == `LSFM_REG_BIAS_THR) begin
                bias_fault_threshold <= lk_msg_data;
            end else if (lk_msg_ptr == `LSFM_REG_PWR_THR) begin
                power_fault_threshold <= lk_msg_data;
            end else if (lk_msg_ptr == `LSFM_REG_CONV) begin
                conv_cfg <= {lk_msg_data[`LSFM_BIT_CONV_PD], lk_msg_data[`LSFM_BIT_CONV_OSC],
                             lk_msg_data[1:0]};
            end
        end
    end

    assign mem.wr_en   = msg_evt && lk_msg_wr && (lk_msg_ptr < `LSFM_REG_COUNT);
    assign mem.wr_addr = lk_msg_ptr[3:0];
    assign mem.wr_data = lk_msg_data;
    assign mem.rd_addr = sys_ptr[3:0];

    lsfm_regmem #(
        .DEPTH (16)
    ) u_regmem (
        .clk_sys (clk_sys),
        .reset   (reset),
        .port    (mem.mem)
    );

    // Result registers take no host writes.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            conv_result <= `LSFM_RST_RESULT;
        end else if (conv_done) begin
            conv_result <= conv_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_byte <= 8'h00;
        end else if (sys_ptr == `LSFM_REG_CTRL0) begin
            rd_byte <= ctrl0;
        end else if (sys_ptr == `LSFM_REG_MON) begin
            rd_byte <= {5'h00, mon_cfg};
        end else if (sys_ptr == `LSFM_REG_BIAS_THR) begin
            rd_byte <= bias_fault_threshold;
        end else if (sys_ptr == `LSFM_REG_PWR_THR) begin
            rd_byte <= power_fault_threshold;
        end else if (sys_ptr == `LSFM_REG_CONV) begin
            rd_byte <= {conv_cfg[3:2], 4'h0, conv_cfg[1:0]};
        end else if (sys_ptr == `LSFM_REG_RES_HI) begin
            rd_byte <= conv_result[9:2];
        end else if (sys_ptr == `LSFM_REG_RES_LO) begin
            rd_byte <= {6'h00, conv_result[1:0]};
        end else if (sys_ptr < `LSFM_REG_COUNT) begin
            rd_byte <= mem.rd_data;
        end else begin
            rd_byte <= 8'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            conv_power_down   <= 1'b0;
            conv_osc_off      <= 1'b0;
            conv_input_select <= 2'h0;
        end else begin
            conv_power_down   <= conv_cfg[3];
            conv_osc_off      <= conv_cfg[2];
            conv_input_select <= conv_cfg[1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prev_dac <= 10'h000;
        end else if (bias_dac_load) begin
            prev_dac <= bias_dac;
        end
    end

    // Fault detection.
    always_comb begin
        if (mon_cfg[`LSFM_BIT_BIAS_DIG]) begin
            bias_fault = at_or_above(bias_meas, bias_fault_threshold);
        end else begin
            bias_fault = bias_pin_s;
        end
        if (mon_cfg[`LSFM_BIT_PWR_DIG]) begin
            power_fault = at_or_above(pd_meas, power_fault_threshold);
        end else begin
            power_fault = power_pin_s && mon_cfg[`LSFM_BIT_PWR_TRIP];
        end
        pd_over = {1'b0, pd_current, 1'b0} >
                  ({2'b00, pd_setpoint} + {1'b0, pd_setpoint, 1'b0});
        dac_drop = bias_dac_load && ({bias_dac, 1'b0} < {1'b0, prev_dac});
        fault_cond = bias_fault || power_fault || pd_over || dac_drop;
    end

    assign disabled = shutoff_s || !ctrl0[`LSFM_BIT_CHIP_ON];

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dis_cnt <= 16'h0000;
        end else if (!disabled) begin
            dis_cnt <= 16'h0000;
        end else if (dis_cnt != LATCH_CYC) begin
            dis_cnt <= dis_cnt + 16'h0001;
        end
    end

    always_comb begin
        next_fault_latch = fault_latch;
        if (disabled && dis_cnt == LATCH_CYC) begin
            next_fault_latch = 1'b0;
        end else if (!disabled && ctrl0[`LSFM_BIT_FAULT_EN] && fault_cond) begin
            next_fault_latch = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fault_latch <= 1'b0;
            fault_out   <= 1'b0;
        end else begin
            fault_latch <= next_fault_latch;
            fault_out   <= next_fault_latch && !disabled;
        end
    end

    // Normal drive returns only after the negate time with no fault held.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            run_cnt <= 16'h0000;
            running <= 1'b0;
        end else if (disabled || next_fault_latch) begin
            run_cnt <= 16'h0000;
            running <= 1'b0;
        end else if (run_cnt != NEGATE_CYC) begin
            run_cnt <= run_cnt + 16'h0001;
        end else begin
            running <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bias_force_zero <= 1'b1;
            mod_force_zero  <= 1'b1;
            chip_running    <= 1'b0;
        end else begin
            bias_force_zero <= !running || next_fault_latch;
            mod_force_zero  <= !running || next_fault_latch;
            chip_running    <= running && !next_fault_latch;
        end
    end

endmodule

// ---- lsfm_map.svh ----
`ifndef LSFM_MAP_SVH
`define LSFM_MAP_SVH

`define LSFM_REG_CTRL0    8'h00
`define LSFM_REG_MON      8'h0A
`define LSFM_REG_BIAS_THR 8'h0B
`define LSFM_REG_PWR_THR  8'h0C
`define LSFM_REG_CONV     8'h0D
`define LSFM_REG_RES_HI   8'h0E
`define LSFM_REG_RES_LO   8'h0F
`define LSFM_REG_COUNT    8'h10

`define LSFM_BIT_CHIP_ON  7
`define LSFM_BIT_FAULT_EN 3
`define LSFM_BIT_PWR_TRIP 2
`define LSFM_BIT_PWR_DIG  1
`define LSFM_BIT_BIAS_DIG 0
`define LSFM_BIT_CONV_PD  7
`define LSFM_BIT_CONV_OSC 6

`define LSFM_RST_CTRL0    8'h00
`define LSFM_RST_MON      3'h0
`define LSFM_RST_THR      8'h00
`define LSFM_RST_CONV     4'h0
`define LSFM_RST_RESULT   10'h000

`define LSFM_CLK_MHZ      100
`define LSFM_LATCH_RST_NS 1000
`define LSFM_NEGATE_NS    2000

// Bus address of the device; the value is arbitrary.
`define LSFM_DEV_ADDR     7'h2A

`endif

// ---- lsfm_pkg.sv ----
package lsfm_pkg;

    typedef enum logic [2:0] {
        LSFM_LK_ADDR,
        LSFM_LK_REG,
        LSFM_LK_WRITE,
        LSFM_LK_READ,
        LSFM_LK_IDLE
    } lsfm_link_state_t;

endpackage

// ---- lsfm_mem_if.sv ----
`timescale 1ns/1ps

interface lsfm_mem_if;
    logic       wr_en;
    logic [3:0] wr_addr;
    logic [7:0] wr_data;
    logic [3:0] rd_addr;
    logic [7:0] rd_data;

    modport core (output wr_en, output wr_addr, output wr_data, output rd_addr,
                  input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr,
                  output rd_data);
endinterface

// ---- lsfm_sync2.sv ----
`timescale 1ns/1ps

module lsfm_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule

// ---- lsfm_regmem.sv ----
`timescale 1ns/1ps

module lsfm_regmem #(
    parameter int DEPTH = 16
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    lsfm_mem_if.mem   port
);
    logic [7:0] cells [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                cells[i] <= 8'h00;
            end
        end else if (port.wr_en) begin
            cells[port.wr_addr] <= port.wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            port.rd_data <= 8'h00;
        end else begin
            port.rd_data <= cells[port.rd_addr];
        end
    end
endmodule

// ---- lsfm_host_model.sv ----
`timescale 1ns/1ps

module lsfm_host_model #(
    parameter logic [6:0] ADDR = 7'h00
) (
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda_line
);
    localparam realtime Q = 31.25;
    logic r;

    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Data moves only while the clock is low; the line is sampled mid-high.
    task automatic bit_x(input logic b);
        sda_drv = b;
        #Q scl = 1'b1;
        #Q r = sda_line;
        #Q scl = 1'b0;
        #Q;
    endtask

    // A start (or repeated start) when p is low, a stop when p is high.
    task automatic cond(input logic p);
        sda_drv = !p;
        #Q scl = 1'b1;
        #(2 * Q) sda_drv = p;
        #(2 * Q) scl = p;
        #Q;
    endtask

    // The ninth bit is always released, so read data ends with a not-acknowledge.
    task automatic byte_x(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i]);
            q[i] = r;
        end
        bit_x(1'b1);
    endtask

    task automatic access(input logic rd, input logic [7:0] a, inout logic [7:0] d,
                          output logic ok);
        logic [7:0] q;
        ok = 1'b1;
        cond(1'b0);
        byte_x({ADDR, 1'b0}, q);
        ok &= !r;
        byte_x(a, q);
        ok &= !r;
        if (rd) begin
            cond(1'b0);
            byte_x({ADDR, 1'b1}, q);
            ok &= !r;
            byte_x(8'hFF, d);
        end else begin
            byte_x(d, q);
            ok &= !r;
        end
        cond(1'b1);
    endtask
endmodule

// ---- lsfm_fault_monitor_props.sv ----
`timescale 1ns/1ps

module lsfm_fault_monitor_chk #(
    parameter int NEGATE_NS = 2000
) (
    input wire logic       clk_sys,
    input wire logic       reset,
    input wire logic       output_shutoff_in,
    input wire logic       fault_out,
    input wire logic       bias_force_zero,
    input wire logic       mod_force_zero,
    input wire logic       chip_running,
    input wire logic       conv_power_down,
    input wire logic       conv_osc_off,
    input wire logic [1:0] conv_input_select
);
    localparam int NEGATE_CYC = NEGATE_NS / 10;
    int quiet_cnt;

    // Cycles since the shutoff pin was last high, saturating.
    always_ff @(posedge clk_sys) begin
        if (reset || output_shutoff_in) begin
            quiet_cnt <= 0;
        end else if (quiet_cnt < 100000) begin
            quiet_cnt <= quiet_cnt + 1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_shutoff_held;
        output_shutoff_in [*5];
    endsequence

    a_fault_safe_state: assert property (
        fault_out |-> bias_force_zero && mod_force_zero && !chip_running)
        else $error("fault without safe outputs");
    a_shutoff_clears_fault: assert property (s_shutoff_held |-> !fault_out)
        else $error("fault output high while shut off");
    a_shutoff_stops_drive: assert property (s_shutoff_held |-> !chip_running)
        else $error("running while shut off");
    a_fault_rise_enabled: assert property (
        $rose(fault_out) |-> !$past(output_shutoff_in, 2))
        else $error("fault rose while shut off");
    a_run_drive_on: assert property (
        chip_running |-> !bias_force_zero && !mod_force_zero)
        else $error("running with currents forced to zero");
    a_resume_delay: assert property ($rose(chip_running) |-> quiet_cnt >= NEGATE_CYC)
        else $error("resumed before negate time");
    a_fault_clear_idle: assert property ($fell(fault_out) |-> !chip_running [*8])
        else $error("resumed at once after fault cleared");
    a_reset_safe: assert property (
        $fell(reset) |-> !fault_out && bias_force_zero && mod_force_zero && !chip_running)
        else $error("unsafe outputs after reset");
    a_conv_reset: assert property (
        $fell(reset) |-> !conv_power_down && !conv_osc_off && conv_input_select == 2'h0)
        else $error("converter outputs not cleared by reset");
endmodule

bind lsfm_fault_monitor lsfm_fault_monitor_chk #(.NEGATE_NS(NEGATE_NS)) u_chk (
    .clk_sys, .reset, .output_shutoff_in, .fault_out, .bias_force_zero, .mod_force_zero,
    .chip_running, .conv_power_down, .conv_osc_off, .conv_input_select);

// ---- test_lsfm_fault_monitor.sv ----
`timescale 1ns/1ps
`include "lsfm_map.svh"

module test_lsfm_fault_monitor;
    localparam int LATCH_CYC = 100;
    localparam int NEGATE_CYC = 200;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        scl_clk, host_sda, sda_in, sda_out, sda_oe;
    logic        output_shutoff_in = 1'b0, bias_monitor_pin = 1'b0, power_monitor_pin = 1'b0;
    logic [7:0]  bias_meas = 8'h00, pd_meas = 8'h00;
    logic [9:0]  pd_current = 10'h064, pd_setpoint = 10'h0C8;
    logic [9:0]  bias_dac = 10'h000, conv_data = 10'h000;
    logic        bias_dac_load = 1'b0, conv_done = 1'b0, drop = 1'b0;
    logic        fault_out, bias_force_zero, mod_force_zero, chip_running;
    logic        conv_power_down, conv_osc_off;
    logic [1:0]  conv_input_select;
    logic [15:0] state;
    int          mreg[17];
    int          mon_tab[9] = '{0, 1, 4, 2, 0, 0, 0, 1, 0};
    int          failures = 0, cmp_count = 0, cycles = 0;

    always #5 clk_sys = ~clk_sys;
    // Open-drain line with a pull-up.
    assign sda_in = host_sda & ~(sda_oe & ~sda_out);
    assign state = {12'h000, fault_out, bias_force_zero, mod_force_zero, chip_running};

    lsfm_host_model #(.ADDR(`LSFM_DEV_ADDR)) u_host (
        .scl(scl_clk), .sda_drv(host_sda), .sda_line(sda_in));

    lsfm_fault_monitor u_lsfm_fault_monitor (
        .clk_sys, .reset, .scl_clk, .sda_in, .sda_out, .sda_oe, .output_shutoff_in,
        .bias_monitor_pin, .power_monitor_pin, .bias_meas, .pd_meas, .pd_current,
        .pd_setpoint, .bias_dac, .bias_dac_load, .conv_data, .conv_done, .fault_out,
        .bias_force_zero, .mod_force_zero, .conv_power_down, .conv_osc_off,
        .conv_input_select, .chip_running);

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            summarize();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input int a, input int d);
        logic [7:0] v;
        logic       ok;
        v = 8'(d);
        u_host.access(1'b0, 8'(a), v, ok);
        if (a < 14) begin
            check(16'(ok), 16'h0001);
            mreg[a] = d;
        end
    endtask

    task automatic rd(input int a);
        logic [7:0] v;
        logic       ok;
        u_host.access(1'b1, 8'(a), v, ok);
        check(16'(ok), 16'h0001);
        check(16'(v), 16'(mreg[a]));
    endtask

    function automatic logic [15:0] exp_state();
        int  m = mreg[10];
        logic c;
        c = ((m & 1) ? (bias_meas >= mreg[11]) : bias_monitor_pin)
            || ((m & 2) ? (pd_meas >= mreg[12]) : ((m & 4) != 0 && power_monitor_pin))
            || (2 * pd_current > 3 * pd_setpoint) || drop;
        return ((mreg[0] & 136) == 136 && c) ? 16'h000E : 16'h0001;
    endfunction

    task automatic load_dac(input logic [9:0] v);
        bias_dac <= v;
        bias_dac_load <= 1'b1;
        @(posedge clk_sys);
        bias_dac_load <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic set_cond(input int k, input logic on);
        @(posedge clk_sys);
        case (k)
            0, 8: bias_monitor_pin <= on;
            1: bias_meas <= on ? 8'(mreg[11]) : 8'h00;
            2, 6: power_monitor_pin <= on;
            3: pd_meas <= on ? 8'(mreg[12]) : 8'h00;
            4: pd_current <= on ? 10'h12D : 10'h064;
            5: begin
                drop = on;
                if (on) load_dac(10'h190);
                if (on) load_dac(10'h0C7);
            end
            default: begin
                bias_monitor_pin <= on;
                bias_meas <= on ? 8'(mreg[11] - 1) : 8'h00;
            end
        endcase
        @(posedge clk_sys);
    endtask

    task automatic recover(input logic via_bit);
        if (via_bit) begin
            wr(0, 8);
            check(state, 16'h0006);
            wr(0, 136);
        end else begin
            @(posedge clk_sys);
            output_shutoff_in <= 1'b1;
            repeat (LATCH_CYC + 5) @(posedge clk_sys);
            check(state, 16'h0006);
            output_shutoff_in <= 1'b0;
        end
    endtask

    initial begin
        int  k;
        logic f;
        void'($urandom(32'hE0162B58));
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check(state, 16'h0006);
        wr(11, 1 + $urandom % 255);
        wr(12, 1 + $urandom % 255);
        for (int s = 0; s < 4; s++) begin
            k = ($urandom % 4) * 64 + s;
            wr(13, k);
            check(16'({conv_power_down, conv_osc_off, conv_input_select}), 16'(k / 16 + s));
            conv_data <= 10'($urandom);
            conv_done <= 1'b1;
            @(posedge clk_sys);
            conv_done <= 1'b0;
            mreg[14] = conv_data >> 2;
            mreg[15] = conv_data & 3;
            wr(14 + s % 3, 255);
            for (int a = 11; a <= 16; a++) rd(a);
        end
        wr(0, 136);
        for (k = 0; k < 9; k++) begin
            wr(10, mon_tab[k]);
            wr(0, k == 8 ? 128 : 136);
            repeat (NEGATE_CYC + 10) @(posedge clk_sys);
            check(state, 16'h0001);
            set_cond(k, 1'b1);
            repeat (6) @(posedge clk_sys);
            f = exp_state() == 16'h000E;
            check(state, exp_state());
            if (f && k == 0) begin
                recover(1'b0);
                repeat (6) @(posedge clk_sys);
                check(state, 16'h000E);
            end
            set_cond(k, 1'b0);
            if (f) begin
                recover(k == 1);
                repeat (NEGATE_CYC + 10) @(posedge clk_sys);
            end
            check(state, 16'h0001);
        end
        summarize();
    end
endmodule
